// ---- hdl/ddrmr_pkg.sv ----
// Package for the mode register 0 and 1 decode block: field positions, codes, structs.
// Assumes a single mclk domain and the command pins already sampled into that domain.
// Behaviour
// - DLL reset bit clears itself after reset.
// - Fixed four-beat burst pulls write two clocks.
// - Write recovery field combines with precharge time; this block only decodes it into cfg.wr_code.
// - Power-down DLL policy chooses slow or fast exit.
// - Command decode selects mode register one write.
// - Additive latency decoded from two field bits.
// - Nominal termination decoded from three field bits.
// - Driver impedance decoded from two field bits.
// - DLL stops during self-refresh, returns after.
// - Commands held additive latency before internal issue.
// - Output-off bit disconnects data and strobe outputs.
// - Termination strobe only on byte-wide configuration; here bit 11 alone enables it, with no width input.
// - Write leveling mode entered by leveling bit.
// - Writes need DLL only with dynamic termination.
// - Write termination applies even with nominal off.
package ddrmr_pkg;

    // Address bit positions for mode register 0.
    localparam int MR0_BL_LO   = 0;
    localparam int MR0_BL_HI   = 1;
    localparam int MR0_TEST    = 7;
    localparam int MR0_DLLRST  = 8;
    localparam int MR0_WR_LO   = 9;
    localparam int MR0_WR_HI   = 11;
    localparam int MR0_PPD     = 12;

    // Address bit positions for mode register 1.
    localparam int MR1_DLLDIS  = 0;
    localparam int MR1_DIC0    = 1;
    localparam int MR1_RTT0    = 2;
    localparam int MR1_AL0     = 3;
    localparam int MR1_AL1     = 4;
    localparam int MR1_DIC1    = 5;
    localparam int MR1_RTT1    = 6;
    localparam int MR1_LEVEL   = 7;
    localparam int MR1_ZERO8   = 8;
    localparam int MR1_RTT2    = 9;
    localparam int MR1_ZERO10  = 10;
    localparam int MR1_TSTRB   = 11;
    localparam int MR1_QOFF    = 12;
    localparam int MR1_ZERO13  = 13;
    localparam int MR1_ZERO14  = 14;

    // Burst length codes.
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF  = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    localparam logic [1:0] BL_RSVD = 2'h3;

    // Additive latency codes.
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CLM1 = 2'h1;
    localparam logic [1:0] AL_CLM2 = 2'h2;
    localparam logic [1:0] AL_RSVD = 2'h3;

    // Nominal termination codes {A9,A6,A2}.
    localparam logic [2:0] RTT_OFF  = 3'h0;
    localparam logic [2:0] RTT_DIV4 = 3'h1;
    localparam logic [2:0] RTT_DIV2 = 3'h2;
    localparam logic [2:0] RTT_DIV6 = 3'h3;
    localparam logic [2:0] RTT_DIV12 = 3'h4;
    localparam logic [2:0] RTT_DIV8 = 3'h5;

    // Driver impedance codes {A5,A1}.
    localparam logic [1:0] DIC_DIV6 = 2'h0;
    localparam logic [1:0] DIC_DIV7 = 2'h1;

    // Write recovery reserved code.
    localparam logic [2:0] WR_RSVD = 3'h0;

    // Bank select for the mode register targets.
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;

    // Pull-in of the internal write point for fixed four-beat bursts, in clocks.
    localparam logic [3:0] BC4_PULLIN = 4'h2;

    // Reset values of the stored fields.
    localparam logic [15:0] MR0_RST = 16'h0000;
    localparam logic [15:0] MR1_RST = 16'h0000;

    // Width of the additive latency delay line.
    localparam int AL_MAX = 16;

    // Command pins, active low strobes, as sampled.
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [15:0] addr;
    } ddrmr_cmd_t;

    // Decoded configuration presented to the rest of the device.
    typedef struct packed {
        logic       dll_on;
        logic       ppd_fast;
        logic [2:0] wr_code;
        logic [1:0] al_code;
        logic [2:0] rtt_nom;
        logic [1:0] dic;
        logic       level;
        logic       tstrb_en;
        logic       out_off;
    } ddrmr_cfg_t;

endpackage

// ---- hdl/ddrmr_aldly.sv ----
// Delay line that holds a read or write command for the additive latency.
// Assumes the latency value is stable while commands are in flight.
`timescale 1ns/10ps
module ddrmr_aldly (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       srst,
    // Command entering from the pins.
    input  wire logic       cmd_in,
    input  wire logic [3:0] lat,
    // Command issued internally.
    output logic            cmd_out
);

    logic [ddrmr_pkg::AL_MAX-1:0] pipe_r; // Shift chain, one stage a clock.

    // Shift the command through the chain each clock.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pipe_r <= '0;
        end else begin
            pipe_r <= {pipe_r[ddrmr_pkg::AL_MAX-2:0], cmd_in};
        end
    end

    // Zero latency passes straight through; otherwise tap the chain.
    assign cmd_out = (lat == 4'h0) ? cmd_in : pipe_r[lat - 4'h1];

endmodule

// ---- hdl/ddrmr_top.sv ----
// Mode register 0 and 1 store and decode for the memory device.
// Assumes the command pins are already registered on mclk by the input stage.
`timescale 1ns/10ps
module ddrmr_top (
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // Command bus from the pins.
    input  wire ddrmr_pkg::ddrmr_cmd_t cmd,
    input  wire logic                  cke,
    // Device state and timing inputs.
    input  wire logic [3:0]            cas_lat,
    input  wire logic                  self_ref,
    input  wire logic                  pdn,
    input  wire logic                  dll_rst_done,
    input  wire logic                  wr_dyn_en,
    input  wire logic                  wr_cmd,
    input  wire logic                  rd_cmd,
    // Configuration and control out.
    output ddrmr_pkg::ddrmr_cfg_t      cfg,
    output logic                       dll_rst_req,
    output logic                       dll_run,
    output logic [3:0]                 add_lat,
    output logic                       bc4_pullin,
    output logic [3:0]                 wr_pullin,
    output logic                       data_out_en,
    output logic                       termination_strobe_en,
    output logic                       wr_rtt_apply,
    output logic                       wr_needs_dll,
    output logic                       rd_issue,
    output logic                       wr_issue,
    output logic                       rsvd_err
);

    logic [15:0] mr0_r;          // Stored mode register 0 image.
    logic [15:0] mr1_r;          // Stored mode register 1 image.
    logic        dll_rst_r;      // DLL reset bit, self-clearing.
    logic        dll_run_r;      // DLL running state.
    logic        err_r;          // Sticky reserved-code flag.
    logic [3:0]  al_r;           // Registered additive latency.
    logic        rd_dl;          // Read after the latency delay.
    logic        wr_dl;          // Write after the latency delay.
    logic        rd_iss_r;       // Registered internal read.
    logic        wr_iss_r;       // Registered internal write.
    logic        wr_apply_r;     // Registered write termination apply.
    logic        wr_dll_r;       // Registered write-needs-DLL flag.
    ddrmr_pkg::ddrmr_cfg_t cfg_r; // Registered configuration view.
    logic        bc4_r;          // Registered fixed four-beat flag.
    logic [3:0]  pull_r;         // Registered write pull-in, in clocks.
    logic        oen_r;          // Registered data and strobe output enable.
    logic        tstrb_r;        // Registered termination strobe enable.

    // Decode a mode register set command to a given bank.
    function automatic logic is_mrs(input ddrmr_pkg::ddrmr_cmd_t c, input logic [2:0] b);
        is_mrs = !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n && (c.ba == b);
    endfunction

    // Decode a pair of register images into the configuration view.
    function automatic ddrmr_pkg::ddrmr_cfg_t cfg_of(input logic [15:0] m0,
                                                     input logic [15:0] m1);
        cfg_of.dll_on   = !m1[ddrmr_pkg::MR1_DLLDIS];
        cfg_of.ppd_fast = m0[ddrmr_pkg::MR0_PPD];
        cfg_of.wr_code  = m0[ddrmr_pkg::MR0_WR_HI:ddrmr_pkg::MR0_WR_LO];
        cfg_of.al_code  = {m1[ddrmr_pkg::MR1_AL1], m1[ddrmr_pkg::MR1_AL0]};
        cfg_of.rtt_nom  = {m1[ddrmr_pkg::MR1_RTT2], m1[ddrmr_pkg::MR1_RTT1],
                           m1[ddrmr_pkg::MR1_RTT0]};
        cfg_of.dic      = {m1[ddrmr_pkg::MR1_DIC1], m1[ddrmr_pkg::MR1_DIC0]};
        cfg_of.level    = m1[ddrmr_pkg::MR1_LEVEL];
        cfg_of.tstrb_en = m1[ddrmr_pkg::MR1_TSTRB];
        cfg_of.out_off  = m1[ddrmr_pkg::MR1_QOFF];
    endfunction

    wire mr0_wr = is_mrs(cmd, ddrmr_pkg::BA_MR0); // Write to mode register 0.
    wire mr1_wr = is_mrs(cmd, ddrmr_pkg::BA_MR1);

    // Field views of the stored images.
    wire [1:0] bl_code  = mr0_r[ddrmr_pkg::MR0_BL_HI:ddrmr_pkg::MR0_BL_LO];
    wire [1:0] al_code  = {mr1_r[ddrmr_pkg::MR1_AL1], mr1_r[ddrmr_pkg::MR1_AL0]};
    wire       dll_on   = !mr1_r[ddrmr_pkg::MR1_DLLDIS];

    // Reserved-code checks on the incoming address.
    wire [15:0] a = cmd.addr;
    wire rsv0 = mr0_wr && ((a[ddrmr_pkg::MR0_BL_HI:ddrmr_pkg::MR0_BL_LO] == ddrmr_pkg::BL_RSVD)
                || (a[ddrmr_pkg::MR0_WR_HI:ddrmr_pkg::MR0_WR_LO] == ddrmr_pkg::WR_RSVD)
                || a[ddrmr_pkg::MR0_TEST]);
    wire rsv1 = mr1_wr && (({a[ddrmr_pkg::MR1_AL1], a[ddrmr_pkg::MR1_AL0]} == ddrmr_pkg::AL_RSVD)
                || (a[ddrmr_pkg::MR1_RTT2] && a[ddrmr_pkg::MR1_RTT1])
                || a[ddrmr_pkg::MR1_DIC1]
                || a[ddrmr_pkg::MR1_ZERO8] || a[ddrmr_pkg::MR1_ZERO10]
                || a[ddrmr_pkg::MR1_ZERO13] || a[ddrmr_pkg::MR1_ZERO14]);

    // Additive latency value from the code and CAS latency.
    wire [3:0] al_nxt = (al_code == ddrmr_pkg::AL_CLM1) ? cas_lat - 4'h1 :
                        (al_code == ddrmr_pkg::AL_CLM2) ? cas_lat - 4'h2 : 4'h0;

    // DLL runs when enabled, not in self-refresh, and not frozen in slow-exit power-down.
    wire ppd_fast   = mr0_r[ddrmr_pkg::MR0_PPD];
    wire dll_run_nxt = dll_on && !self_ref && !(pdn && !ppd_fast);

    // Next images with the reset folded in. The output flip-flops load from these,
    // so cfg and the pin-facing enables change at the same edge as the image behind them; dll_run and add_lat follow one edge later.
    wire [15:0] mr0_nxt = srst ? ddrmr_pkg::MR0_RST : (mr0_wr ? a : mr0_r);
    wire [15:0] mr1_nxt = srst ? ddrmr_pkg::MR1_RST : (mr1_wr ? a : mr1_r);
    wire        bc4_nxt = (mr0_nxt[ddrmr_pkg::MR0_BL_HI:ddrmr_pkg::MR0_BL_LO]
                           == ddrmr_pkg::BL_FIX4);

    // Mode register images; the DLL reset bit is held separately.
    always_ff @(posedge mclk) begin
        if (srst) begin
            mr0_r <= ddrmr_pkg::MR0_RST;
            mr1_r <= ddrmr_pkg::MR1_RST;
        end else begin
            if (mr0_wr) begin
                mr0_r <= a;
            end
            if (mr1_wr) begin
                mr1_r <= a;
            end
        end
    end

    // Self-clearing DLL reset: a new request wins over the completion.
    always_ff @(posedge mclk) begin
        if (srst) begin
            dll_rst_r <= 1'b0;
        end else if (mr0_wr && a[ddrmr_pkg::MR0_DLLRST]) begin
            dll_rst_r <= 1'b1;
        end else if (dll_rst_done) begin
            dll_rst_r <= 1'b0;
        end
    end

    // Sticky error flag for reserved codes.
    always_ff @(posedge mclk) begin
        if (srst) begin
            err_r <= 1'b0;
        end else if (rsv0 || rsv1) begin
            err_r <= 1'b1;
        end
    end

    // DLL state and latency registers.
    always_ff @(posedge mclk) begin
        if (srst) begin
            dll_run_r <= 1'b0;
            al_r      <= 4'h0;
        end else begin
            dll_run_r <= dll_run_nxt;
            al_r      <= al_nxt;
        end
    end

    // Output flip-flops for the configuration view and the pin-facing enables.
    always_ff @(posedge mclk) begin
        cfg_r   <= cfg_of(mr0_nxt, mr1_nxt);
        bc4_r   <= bc4_nxt;
        pull_r  <= bc4_nxt ? ddrmr_pkg::BC4_PULLIN : 4'h0;
        oen_r   <= !mr1_nxt[ddrmr_pkg::MR1_QOFF];
        tstrb_r <= mr1_nxt[ddrmr_pkg::MR1_TSTRB];
    end

    // Hold reads and writes for the additive latency.
    ddrmr_aldly u_rd_dly (
        .mclk    (mclk),
        .srst    (srst),
        .cmd_in  (rd_cmd),
        .lat     (al_r),
        .cmd_out (rd_dl)
    );

    ddrmr_aldly u_wr_dly (
        .mclk    (mclk),
        .srst    (srst),
        .cmd_in  (wr_cmd),
        .lat     (al_r),
        .cmd_out (wr_dl)
    );

    // Internal issue and write termination flags.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_iss_r   <= 1'b0;
            wr_iss_r   <= 1'b0;
            wr_apply_r <= 1'b0;
            wr_dll_r   <= 1'b0;
        end else begin
            rd_iss_r   <= rd_dl;
            wr_iss_r   <= wr_dl;
            wr_apply_r <= wr_dl && wr_dyn_en && !mr1_r[ddrmr_pkg::MR1_LEVEL];
            wr_dll_r   <= wr_dyn_en;
        end
    end

    // Outputs, each straight from a flip-flop.
    assign cfg           = cfg_r;
    assign dll_rst_req   = dll_rst_r;
    assign dll_run       = dll_run_r;
    assign add_lat       = al_r;
    assign bc4_pullin    = bc4_r;
    assign wr_pullin     = pull_r;
    assign data_out_en   = oen_r;
    assign termination_strobe_en = tstrb_r;
    assign wr_rtt_apply  = wr_apply_r;
    assign wr_needs_dll  = wr_dll_r;
    assign rd_issue      = rd_iss_r;
    assign wr_issue      = wr_iss_r;
    assign rsvd_err      = err_r;

    // Assertions.
    sequence s_rst_set;
        mr0_wr && a[ddrmr_pkg::MR0_DLLRST];
    endsequence

    a_mr1_capture: assert property (@(posedge mclk) disable iff (srst)
        mr1_wr |=> (mr1_r == $past(a)))
        else $error("mode register 1 not captured");

    a_dllrst_clear: assert property (@(posedge mclk) disable iff (srst)
        (dll_rst_r && dll_rst_done && !(mr0_wr && a[ddrmr_pkg::MR0_DLLRST])) |=> !dll_rst_r)
        else $error("DLL reset bit did not clear");

    a_dllrst_set: assert property (@(posedge mclk) disable iff (srst)
        s_rst_set |=> dll_rst_r)
        else $error("DLL reset bit not set");

    a_sr_dll_off: assert property (@(posedge mclk) disable iff (srst)
        self_ref |=> !dll_run_r)
        else $error("DLL running in self-refresh");

    a_ppd_slow: assert property (@(posedge mclk) disable iff (srst)
        (pdn && !ppd_fast && !self_ref && dll_on) |=> !dll_run_r)
        else $error("DLL not frozen in slow exit");

    a_qoff_out: assert property (@(posedge mclk) disable iff (srst)
        (mr1_wr && a[ddrmr_pkg::MR1_QOFF]) |=> !data_out_en)
        else $error("outputs not disconnected");

    a_al_value: assert property (@(posedge mclk) disable iff (srst)
        ##1 (al_code == ddrmr_pkg::AL_CLM2 && $stable(al_code) && $stable(cas_lat))
        |=> (al_r == cas_lat - 4'h2))
        else $error("additive latency wrong");

    a_rd_zero_al: assert property (@(posedge mclk) disable iff (srst)
        (rd_cmd && al_r == 4'h0) |=> rd_iss_r)
        else $error("read not issued at zero latency");

    a_rsvd_flag: assert property (@(posedge mclk) disable iff (srst)
        (mr1_wr && a[ddrmr_pkg::MR1_AL1] && a[ddrmr_pkg::MR1_AL0]) |=> err_r)
        else $error("reserved code not flagged");

    a_bc4_pull: assert property (@(posedge mclk) disable iff (srst)
        (bl_code == ddrmr_pkg::BL_OTF) |-> (wr_pullin == 4'h0))
        else $error("pull-in during on-the-fly");

    // Stored images and the decoded view follow each write one edge later.
    a_mr0_capture: assert property (@(posedge mclk) disable iff (srst)
        mr0_wr |=> (mr0_r == $past(a)))
        else $error("mode register 0 not captured");

    a_wr_field: assert property (@(posedge mclk) disable iff (srst)
        mr0_wr |=> (cfg.wr_code == $past(a[ddrmr_pkg::MR0_WR_HI:ddrmr_pkg::MR0_WR_LO])))
        else $error("write recovery field wrong");

    a_rtt_field: assert property (@(posedge mclk) disable iff (srst)
        mr1_wr |=> (cfg.rtt_nom == $past({a[ddrmr_pkg::MR1_RTT2], a[ddrmr_pkg::MR1_RTT1],
                                          a[ddrmr_pkg::MR1_RTT0]})))
        else $error("nominal termination field wrong");

    a_dic_field: assert property (@(posedge mclk) disable iff (srst)
        mr1_wr |=> (cfg.dic == $past({a[ddrmr_pkg::MR1_DIC1], a[ddrmr_pkg::MR1_DIC0]})))
        else $error("driver impedance field wrong");

    a_level_field: assert property (@(posedge mclk) disable iff (srst)
        mr1_wr |=> (cfg.level == $past(a[ddrmr_pkg::MR1_LEVEL])))
        else $error("write leveling bit wrong");

    a_tstrb_out: assert property (@(posedge mclk) disable iff (srst)
        mr1_wr |=> (termination_strobe_en == $past(a[ddrmr_pkg::MR1_TSTRB])))
        else $error("termination strobe enable wrong");

    // A new DLL reset request wins over a completion in the same cycle.
    a_dllrst_win: assert property (@(posedge mclk) disable iff (srst)
        (s_rst_set ##0 dll_rst_done) |=> dll_rst_r)
        else $error("DLL reset request lost to completion");

    // The DLL runs again once self-refresh and slow-exit power-down are gone.
    a_sr_dll_back: assert property (@(posedge mclk) disable iff (srst)
        (dll_on && !self_ref && !pdn) |=> dll_run_r)
        else $error("DLL not running after self-refresh");

    a_pd_fast: assert property (@(posedge mclk) disable iff (srst)
        (pdn && ppd_fast && dll_on && !self_ref) |=> dll_run_r)
        else $error("DLL stopped in fast exit");

    a_al_zero: assert property (@(posedge mclk) disable iff (srst)
        (al_code == ddrmr_pkg::AL_ZERO) |=> (al_r == 4'h0))
        else $error("additive latency not zero");

    // Writes at zero latency issue at once and, with dynamic termination on and leveling off, carry the write termination.
    a_wr_zero_al: assert property (@(posedge mclk) disable iff (srst)
        (wr_cmd && al_r == 4'h0) |=> wr_iss_r)
        else $error("write not issued at zero latency");

    a_wr_apply: assert property (@(posedge mclk) disable iff (srst)
        (wr_cmd && al_r == 4'h0 && wr_dyn_en && !cfg.level) |=> wr_rtt_apply)
        else $error("write termination not applied");

    a_wr_dll: assert property (@(posedge mclk) disable iff (srst)
        wr_dyn_en |=> wr_needs_dll)
        else $error("write DLL need not flagged");

endmodule

// ---- tb/ddrmr_ctl_model.sv ----
// Behavioural memory controller that issues mode register writes to the block.
// Assumes the bench raises go just after a clock edge for one cycle per write.
`timescale 1ns/10ps
module ddrmr_ctl_model (
    // Clock.
    input  wire logic             mclk,
    // Write request from the bench; bad skips the zeroing of must-be-zero bits.
    input  wire logic             go,
    input  wire logic             bad,
    input  wire logic [2:0]       ba,
    input  wire logic [15:0]      addr,
    // Pins toward the device.
    output ddrmr_pkg::ddrmr_cmd_t cmd,
    output logic                  cke
);
    logic [15:0] keep_w;      // Mask of bits the controller may set.
    logic [15:0] safe_w;      // Address as driven on the pins.
    logic [18:0] last_r = '0; // Last bank and address driven.

    // Test bit of register zero cleared unless bad is set.
    // Unused bits of register one cleared, and termination off with the DLL off.
    assign keep_w = (ba == ddrmr_pkg::BA_MR1) ? (addr[0] ? 16'h98bb : 16'h9aff) :
                    (ba == ddrmr_pkg::BA_MR0) ? 16'h9f7f : 16'hffff;
    assign safe_w = bad ? addr : (addr & keep_w);
    // Clock enable stays high; nothing here waits out the lock interval.
    assign cke = 1'b1;
    // Deselected pins show the inverse of the last value, never a stale copy.
    assign cmd = go ? {4'h0, ba, safe_w} : {4'hf, ~last_r};

    // Remember what was driven last.
    always_ff @(posedge mclk) begin
        if (go) begin
            last_r <= {ba, safe_w};
        end
    end
endmodule

// ---- tb/test_ddrmr_top.sv ----
// Self-checking bench for the mode register block with a controller model.
// Assumes one 100 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/10ps
module test_ddrmr_top;
    logic mclk, srst, go, bad, cke, self_ref, pdn, dll_rst_done;
    logic wr_dyn_en, wr_cmd, rd_cmd, dll_rst_req, dll_run, bc4_pullin;
    logic data_out_en, termination_strobe_en, wr_rtt_apply, wr_needs_dll;
    logic rd_issue, wr_issue, rsvd_err;
    logic [2:0]            ba;
    logic [3:0]            cas_lat, add_lat, wr_pullin;
    logic [15:0]           addr;
    ddrmr_pkg::ddrmr_cmd_t cmd;
    ddrmr_pkg::ddrmr_cfg_t cfg;
    int                    failures, checked, cycles, n;

    ddrmr_ctl_model u_ddrmr_ctl_model (.mclk(mclk), .go(go), .bad(bad), .ba(ba),
        .addr(addr), .cmd(cmd), .cke(cke));
    ddrmr_top u_ddrmr_top (.mclk(mclk), .srst(srst), .cmd(cmd), .cke(cke),
        .cas_lat(cas_lat), .self_ref(self_ref), .pdn(pdn), .dll_rst_done(dll_rst_done),
        .wr_dyn_en(wr_dyn_en), .wr_cmd(wr_cmd), .rd_cmd(rd_cmd), .cfg(cfg),
        .dll_rst_req(dll_rst_req), .dll_run(dll_run), .add_lat(add_lat),
        .bc4_pullin(bc4_pullin), .wr_pullin(wr_pullin), .data_out_en(data_out_en),
        .termination_strobe_en(termination_strobe_en), .wr_rtt_apply(wr_rtt_apply),
        .wr_needs_dll(wr_needs_dll), .rd_issue(rd_issue), .wr_issue(wr_issue),
        .rsvd_err(rsvd_err));

    // Free-running clock.
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    // Cuts a hang short.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Waits for n edges and lands just after the last.
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // One mode register write through the controller model.
    task automatic mrs(input logic [2:0] b, input logic [15:0] a);
        go = 1;
        ba = b;
        addr = a;
        tick(1);
        go = 0;
    endtask

    // Sends a read or write and counts cycles to its internal issue.
    task automatic issue(input logic w);
        rd_cmd = !w;
        wr_cmd = w;
        tick(1);
        rd_cmd = 0;
        wr_cmd = 0;
        n = 0;
        while ((w ? wr_issue : rd_issue) !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
    endtask

    // Walks termination, latency, impedance and flag codes of register one.
    task automatic t_mr1;
        logic [15:0] a;
        logic [1:0]  al;
        cas_lat = 4'h9;
        for (int i = 0; i < 6; i++) begin
            al = 2'(i % 3);
            // Leveling with outputs on uses only the narrow termination set.
            a = {3'h0, i[2], i[1], 1'b0, i[2], 1'b0, i[0], i[1], 1'b0, al, i[0], i[0], 1'b0};
            mrs(ddrmr_pkg::BA_MR1, a);
            check(cfg.rtt_nom, 16'(i));
            check(cfg.dic, {15'h0, i[0]});
            check(cfg.level, i[0]);
            check(termination_strobe_en, i[1]);
            check(data_out_en, !i[2]);
            check(cfg.out_off, i[2]);
            check(cfg.tstrb_en, i[1]);
            tick(1);
            check(add_lat, (al == 0) ? 16'h0 : (al == 1) ? 16'h8 : 16'h7);
            check(cfg.al_code, al);
        end
        mrs(3'h2, 16'h0000);
        check(cfg.rtt_nom, 16'h5);
        check(rsvd_err, 0);
    endtask

    // Burst pull-in, DLL reset self-clear and write recovery.
    task automatic t_mr0;
        mrs(ddrmr_pkg::BA_MR0, 16'h0302);
        check(bc4_pullin, 1);
        check(wr_pullin, 16'h2);
        check(cfg.wr_code, 16'h1);
        check(dll_rst_req, 1);
        dll_rst_done = 1;
        tick(1);
        dll_rst_done = 0;
        check(dll_rst_req, 0);
        // A new request and a completion in one cycle: the request stays.
        dll_rst_done = 1;
        mrs(ddrmr_pkg::BA_MR0, 16'h0302);
        dll_rst_done = 0;
        check(dll_rst_req, 1);
        mrs(ddrmr_pkg::BA_MR0, 16'h1201);
        check(bc4_pullin, 0);
        check(wr_pullin, 16'h0);
        check(cfg.ppd_fast, 1);
    endtask

    // Power-down policy and self-refresh stop of the DLL.
    task automatic t_dll;
        pdn = 1;
        tick(3);
        check(dll_run, 1);
        mrs(ddrmr_pkg::BA_MR0, 16'h0200);
        tick(2);
        check(dll_run, 0);
        pdn = 0;
        self_ref = 1;
        tick(3);
        check(dll_run, 0);
        self_ref = 0;
        tick(3);
        check(dll_run, 1);
        // DLL off: the controller model also clears the nominal termination.
        mrs(ddrmr_pkg::BA_MR1, 16'h0245);
        check(cfg.dll_on, 0);
        check(cfg.rtt_nom, 16'h0);
        tick(2);
        check(dll_run, 0);
    endtask

    // Additive latency hold of commands, with write termination and DLL need.
    task automatic t_lat;
        cas_lat = 4'h5;
        wr_dyn_en = 1;
        // DLL switched back on by this write only two edges before the read goes out.
        mrs(ddrmr_pkg::BA_MR1, 16'h0010);
        tick(1);
        check(add_lat, 16'h3);
        issue(0);
        check(16'(n), 16'h3);
        issue(1);
        check(16'(n), 16'h3);
        check(wr_rtt_apply, 1);
        check(wr_needs_dll, 1);
        // Zero additive latency: commands issue on the next edge.
        mrs(ddrmr_pkg::BA_MR1, 16'h0000);
        tick(1);
        issue(0);
        check(16'(n), 16'h0);
        issue(1);
        check(16'(n), 16'h0);
        check(wr_rtt_apply, 1);
        wr_dyn_en = 0;
        tick(2);
        check(wr_needs_dll, 0);
    endtask

    // Reserved codes set the sticky flag; a mid-run reset clears it.
    task automatic t_rsvd;
        bad = 1;
        mrs(ddrmr_pkg::BA_MR1, 16'h0100);
        bad = 0;
        tick(3);
        check(rsvd_err, 1);
        srst = 1;
        tick(1);
        srst = 0;
        check(rsvd_err, 0);
        check(data_out_en, 1);
        mrs(ddrmr_pkg::BA_MR1, 16'h0018);
        tick(1);
        check(rsvd_err, 1);
    endtask

    // Prints the verdict and ends the run.
    task automatic results;
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        {srst, go, bad, self_ref, pdn, dll_rst_done, wr_dyn_en, wr_cmd, rd_cmd} = 9'h100;
        {ba, addr, cas_lat} = '0;
        repeat (12) @(posedge mclk);
        #1;
        srst = 0;
        check(data_out_en, 1);
        check(cfg.dll_on, 1);
        check(rsvd_err, 0);
        t_mr1();
        t_mr0();
        t_dll();
        t_lat();
        t_rsvd();
        results();
    end
endmodule
